/* File: common/boot_pkg.sv */
// boot configuration constants: strap timing, memory map, boot sources
// assumes a 32-bit byte address space and a single system clock domain
package boot_pkg;

    typedef enum logic [1:0] {
        src_main_flash,
        src_system_memory,
        src_embedded_sram
    } boot_src_t;

    // straps are captured on this rising edge after reset or standby exit
    localparam int unsigned    SAMPLE_EDGE       = 4;
    localparam logic [2:0]     SAMPLE_EDGE_CNT   = 3'(SAMPLE_EDGE);

    localparam logic [31:0]    CODE_AREA_BASE    = 32'h0000_0000;
    localparam logic [31:0]    STACK_PTR_ADDR    = 32'h0000_0000;
    localparam logic [31:0]    RESET_VECTOR_ADDR = 32'h0000_0004;
    localparam logic [31:0]    ALIAS_WINDOW_SIZE = 32'h0008_0000;

    localparam logic [31:0]    FLASH_BASE        = 32'h0800_0000;
    localparam logic [31:0]    SYSMEM_BASE       = 32'h1fff_0000;
    localparam logic [31:0]    SRAM_BASE         = 32'h2000_0000;
    localparam logic [31:0]    SRAM_SIZE         = 32'h0001_8000;

    localparam boot_src_t      BOOT_SRC_RESET    = src_main_flash;
    localparam logic [1:0]     REMAP_RESET       = 2'h0;

endpackage

/* File: common/strap_if.sv */
// strap capture handshake between the boot selector and its sampler
// assumes both ends run on mclk
`timescale 1ns/1ps
interface strap_if;
    logic low_level;
    logic high_level;
    logic captured;

    modport sampler
    (
        output low_level,
        output high_level,
        output captured
    );
    modport user
    (
        input  low_level,
        input  high_level,
        input  captured
    );
endinterface

/* File: dv/board_straps.sv */
// board strap model: drives both boot straps to the requested mode
// assumes the bench sets mode ahead of reset release or standby exit
`timescale 1ns/1ps
module board_straps
(
    input  wire logic [1:0] mode,
    output logic            low_pin,
    output logic            high_pin
);
    // levels follow mode for the whole run, standby included
    assign low_pin  = mode[0];
    assign high_pin = mode[1];
endmodule

/* File: dv/boot_alias_chk.sv */
// checker for boot_alias: strap capture timing, decode, remap, sram alias
// assumes binding onto boot_alias with straps held stable around capture
`timescale 1ns/1ps
module boot_alias_chk
    import boot_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        standby_exit,
    input wire logic        boot_select_low_pin,
    input wire logic        boot_select_high_pin,
    input wire logic        remap_write,
    input wire logic [1:0]  remap_wdata,
    input wire logic [31:0] ifetch_addr,
    input wire logic        boot_done,
    input wire logic        shared_pin_released,
    input wire boot_src_t   boot_src,
    input wire logic [1:0]  code_area_remap_register,
    input wire logic        ifetch_sel_sram,
    input wire logic [31:0] ifetch_phys_addr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    AST_CAPTURE_EDGE: assert property (
        $fell(rst) |-> (!shared_pin_released) [*4] ##1 shared_pin_released)
        else $error("strap capture not on fourth edge");
    AST_DONE_LAG: assert property ($rose(shared_pin_released) |=> $rose(boot_done))
        else $error("boot_done not one edge after capture");
    AST_FLASH: assert property (
        $rose(boot_done) && !boot_select_low_pin |-> boot_src == src_main_flash)
        else $error("low strap 0 did not pick flash");
    AST_SYSMEM: assert property (
        $rose(boot_done) && boot_select_low_pin && !boot_select_high_pin
        |-> boot_src == src_system_memory)
        else $error("straps 01 did not pick system memory");
    AST_SRAM: assert property (
        $rose(boot_done) && boot_select_low_pin && boot_select_high_pin
        |-> boot_src == src_embedded_sram)
        else $error("straps 11 did not pick sram");
    // pin flag drops at once, cpu hold follows one edge later
    AST_STANDBY: assert property (
        standby_exit |=> !shared_pin_released ##1 !boot_done ##4 boot_done)
        else $error("standby exit did not resample");
    // writes before recapture are refused, so only count captured cycles
    AST_REMAP: assert property (
        remap_write && remap_wdata != 2'h3 && boot_done && shared_pin_released
        && !standby_exit |=> code_area_remap_register == $past(remap_wdata))
        else $error("remap write not taken");
    AST_SRAM_ALIAS: assert property (
        ifetch_sel_sram |-> boot_done && boot_src == src_embedded_sram
        && ifetch_phys_addr == SRAM_BASE + ifetch_addr)
        else $error("sram code bus hit wrong");
    cover property ($rose(boot_done));
    cover property (ifetch_sel_sram);
    cover property (remap_write && remap_wdata == 2'h3);
endmodule

bind boot_alias boot_alias_chk u_chk (.mclk, .rst, .standby_exit, .boot_select_low_pin,
    .boot_select_high_pin, .remap_write, .remap_wdata, .ifetch_addr, .boot_done,
    .shared_pin_released, .boot_src, .code_area_remap_register, .ifetch_sel_sram,
    .ifetch_phys_addr);

/* File: dv/test_boot_alias.sv */
// bench for boot_alias: strap rows, reset timing, remap, alias edges
// assumes board_straps model and the bound checker
`timescale 1ns/1ps
module test_boot_alias import boot_pkg::*; ;
    typedef struct packed {logic [1:0] m; boot_src_t s; logic [31:0] b;} row_t;
    row_t rows [4] = '{'{2'h0, src_main_flash, FLASH_BASE}, '{2'h2, src_main_flash, FLASH_BASE},
        '{2'h1, src_system_memory, SYSMEM_BASE}, '{2'h3, src_embedded_sram, SRAM_BASE}};
    logic        mclk = 1'b0, rst = 1'b1, standby_exit = 1'b0, remap_write = 1'b0;
    logic [1:0]  mode = 2'h0, remap_wdata = 2'h0, code_area_remap_register;
    logic        ifetch_valid = 1'b1, literal_valid = 1'b1, sysbus_valid = 1'b1;
    logic [31:0] ifetch_addr = RESET_VECTOR_ADDR, literal_addr = STACK_PTR_ADDR;
    logic [31:0] sysbus_addr = SRAM_BASE + 32'h10, sysbus_phys_addr;
    logic [31:0] ifetch_phys_addr, literal_phys_addr;
    logic        low_pin, high_pin, boot_done, shared_pin_released, sysbus_sel_sram;
    logic        ifetch_sel_flash, ifetch_sel_sysmem, ifetch_sel_sram;
    logic        literal_sel_flash, literal_sel_sysmem, literal_sel_sram;
    boot_src_t   boot_src;
    int          errors = 0, n_tests = 0;

    always #12.5 mclk = ~mclk;
    board_straps u_straps (.mode, .low_pin, .high_pin);
    boot_alias u_dut (.mclk, .rst, .standby_exit, .boot_select_low_pin(low_pin),
        .boot_select_high_pin(high_pin), .remap_write, .remap_wdata, .ifetch_valid,
        .ifetch_addr, .literal_valid, .literal_addr, .sysbus_valid, .sysbus_addr, .boot_done,
        .shared_pin_released, .boot_src, .code_area_remap_register, .ifetch_sel_flash,
        .ifetch_sel_sysmem, .ifetch_sel_sram, .ifetch_phys_addr, .literal_sel_flash,
        .literal_sel_sysmem, .literal_sel_sram, .literal_phys_addr, .sysbus_sel_sram,
        .sysbus_phys_addr);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] hot(boot_src_t s);
        return 3'h4 >> s;
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset;
        int n;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk("done in reset", 0, boot_done);
        @(posedge mclk);
        rst <= 1'b0;
        n = 0;
        while (shared_pin_released !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        chk("capture edge", SAMPLE_EDGE + 1, n);
        chk("done lag", 0, boot_done);
        chk("held sel", 0, {ifetch_sel_flash, ifetch_sel_sysmem, ifetch_sel_sram});
        @(negedge mclk);
        chk("done", 1, boot_done);
        $display("reset test ends");
    endtask
    task automatic restart(logic [1:0] m);
        @(posedge mclk);
        mode <= m;
        @(posedge mclk);
        standby_exit <= 1'b1;
        @(posedge mclk);
        standby_exit <= 1'b0;
        repeat (2) @(negedge mclk);
        chk("drop", 0, boot_done);
        repeat (20) if (boot_done !== 1'b1) @(negedge mclk);
        chk("done again", 1, boot_done);
    endtask
    task automatic chk_map(boot_src_t s, logic [31:0] b);
        chk("src", s, boot_src);
        chk("reg", s, code_area_remap_register);
        chk("if sel", hot(s), {ifetch_sel_flash, ifetch_sel_sysmem, ifetch_sel_sram});
        chk("vector", b + RESET_VECTOR_ADDR, ifetch_phys_addr);
        chk("lit sel", hot(s), {literal_sel_flash, literal_sel_sysmem, literal_sel_sram});
        chk("stack", b, literal_phys_addr);
        chk("sys sram", 1, sysbus_sel_sram);
        chk("sys addr", SRAM_BASE + 32'h10, sysbus_phys_addr);
    endtask
    task automatic remap(logic [1:0] v, boot_src_t s, logic [31:0] b);
        @(posedge mclk);
        remap_write <= 1'b1;
        remap_wdata <= v;
        @(posedge mclk);
        remap_write <= 1'b0;
        @(negedge mclk);
        chk_map(s, b);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            restart(rows[i].m);
            chk_map(rows[i].s, rows[i].b);
        end
        $display("strap rows end");
        remap(2'h0, src_main_flash, FLASH_BASE);
        // code 3 must leave the alias alone
        remap(2'h3, src_main_flash, FLASH_BASE);
        remap(2'h1, src_system_memory, SYSMEM_BASE);
        restart(2'h3);
        chk_map(src_embedded_sram, SRAM_BASE);
        $display("remap test ends");
        @(posedge mclk);
        ifetch_addr <= ALIAS_WINDOW_SIZE;
        sysbus_addr <= SRAM_BASE + SRAM_SIZE;
        @(negedge mclk);
        chk("out sel", 0, {ifetch_sel_flash, ifetch_sel_sysmem, ifetch_sel_sram});
        chk("out addr", ALIAS_WINDOW_SIZE, ifetch_phys_addr);
        chk("sys end", 0, sysbus_sel_sram);
        $display("edge test ends");
        do_reset();
        chk("src again", src_embedded_sram, boot_src);
        stop_test();
    end
    initial
    begin
        #20us;
        errors++;
        stop_test();
    end
endmodule

/* File: src/boot_alias.sv */
// boot source selection and code area alias decoder
// assumes one cpu-side request per bus per cycle; memories answer elsewhere
`timescale 1ns/1ps

module boot_alias
    import boot_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          standby_exit,
    input  wire logic          boot_select_low_pin,
    input  wire logic          boot_select_high_pin,
    input  wire logic          remap_write,
    input  wire logic [1:0]    remap_wdata,
    input  wire logic          ifetch_valid,
    input  wire logic [31:0]   ifetch_addr,
    input  wire logic          literal_valid,
    input  wire logic [31:0]   literal_addr,
    input  wire logic          sysbus_valid,
    input  wire logic [31:0]   sysbus_addr,
    output logic               boot_done,
    output logic               shared_pin_released,
    output boot_src_t          boot_src,
    output logic [1:0]         code_area_remap_register,
    output logic               ifetch_sel_flash,
    output logic               ifetch_sel_sysmem,
    output logic               ifetch_sel_sram,
    output logic [31:0]        ifetch_phys_addr,
    output logic               literal_sel_flash,
    output logic               literal_sel_sysmem,
    output logic               literal_sel_sram,
    output logic [31:0]        literal_phys_addr,
    output logic               sysbus_sel_sram,
    output logic [31:0]        sysbus_phys_addr
);

    strap_if    straps ();
    logic       captured_d1_q;
    boot_src_t  strap_src;
    logic [1:0] remap_q;
    logic       cpu_hold_q;

    ////////////////////////////////////////////////////////////////////////
    strap_sampler u_sampler
    (
        .mclk                 (mclk),
        .rst                  (rst),
        .restart              (standby_exit),
        .boot_select_low_pin  (boot_select_low_pin),
        .boot_select_high_pin (boot_select_high_pin),
        .straps               (straps)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        if (!straps.low_level)
            strap_src = src_main_flash;
        else if (!straps.high_level)
            strap_src = src_system_memory;
        else
            strap_src = src_embedded_sram;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            captured_d1_q <= 1'b0;
        else
            captured_d1_q <= straps.captured;
    end

    // fresh capture loads the remap register with the strap decode,
    // later software writes other than code 3 override it until the next capture
    always_ff @(posedge mclk)
    begin
        if (rst)
            remap_q <= REMAP_RESET;
        else if (straps.captured && !captured_d1_q)
            remap_q <= 2'(strap_src);
        else if (remap_write && straps.captured && remap_wdata != 2'h3)
            remap_q <= remap_wdata;
    end

    // cpu is held off until one edge after capture, then fetches from address 0
    always_ff @(posedge mclk)
    begin
        if (rst)
            cpu_hold_q <= 1'b1;
        else
            cpu_hold_q <= !straps.captured;
    end

    assign boot_done                = !cpu_hold_q;
    assign shared_pin_released      = straps.captured;
    assign boot_src                 = boot_src_t'(remap_q);
    assign code_area_remap_register = remap_q;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic in_alias(input logic [31:0] a);
        return a >= CODE_AREA_BASE && a < CODE_AREA_BASE + ALIAS_WINDOW_SIZE;
    endfunction

    function automatic logic in_range(input logic [31:0] a,
                                      input logic [31:0] base,
                                      input logic [31:0] size);
        return a >= base && a - base < size;
    endfunction

    // both code buses share one decode; vector and stack fetches at 0/4
    // land in the alias window like any other code access
    always_comb
    begin
        logic        al;
        logic [31:0] off;
        al  = 1'b0;
        off = 32'h0;
        // instruction bus
        al  = ifetch_valid && boot_done && in_alias(ifetch_addr);
        off = ifetch_addr - CODE_AREA_BASE;
        ifetch_sel_flash  = al && boot_src == src_main_flash;
        ifetch_sel_sysmem = al && boot_src == src_system_memory;
        ifetch_sel_sram   = al && boot_src == src_embedded_sram;
        if (ifetch_sel_flash)
            ifetch_phys_addr = FLASH_BASE + off;
        else if (ifetch_sel_sysmem)
            ifetch_phys_addr = SYSMEM_BASE + off;
        else if (ifetch_sel_sram)
            ifetch_phys_addr = SRAM_BASE + off;
        else
            ifetch_phys_addr = ifetch_addr;
        // literal data bus
        al  = literal_valid && boot_done && in_alias(literal_addr);
        off = literal_addr - CODE_AREA_BASE;
        literal_sel_flash  = al && boot_src == src_main_flash;
        literal_sel_sysmem = al && boot_src == src_system_memory;
        literal_sel_sram   = al && boot_src == src_embedded_sram;
        if (literal_sel_flash)
            literal_phys_addr = FLASH_BASE + off;
        else if (literal_sel_sysmem)
            literal_phys_addr = SYSMEM_BASE + off;
        else if (literal_sel_sram)
            literal_phys_addr = SRAM_BASE + off;
        else
            literal_phys_addr = literal_addr;
    end

    // sram always answers at its own base on the system bus
    assign sysbus_sel_sram  = sysbus_valid
                              && in_range(sysbus_addr, SRAM_BASE, SRAM_SIZE);
    assign sysbus_phys_addr = sysbus_addr;

endmodule

/* File: src/strap_sampler.sv */
// boot strap sampler: synchronises both straps and captures them once per reset or standby exit
// assumes straps are asynchronous pins; restart pulse comes from mclk logic
`timescale 1ns/1ps
module strap_sampler
    import boot_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   rst,
    input  wire logic   restart,
    input  wire logic   boot_select_low_pin,
    input  wire logic   boot_select_high_pin,
    strap_if.sampler    straps
);

    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [2:0] edge_cnt_q;
    logic       armed_q;
    logic       low_q;
    logic       high_q;
    logic       captured_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk)
    begin
        sync1_q <= {boot_select_high_pin, boot_select_low_pin};
        sync2_q <= sync1_q;
    end

    // edge count restarts on reset and on each standby exit
    always_ff @(posedge mclk)
    begin
        if (rst || restart)
        begin
            edge_cnt_q <= 3'h0;
            armed_q    <= 1'b1;
        end
        else if (armed_q)
        begin
            edge_cnt_q <= edge_cnt_q + 3'h1;
            if (edge_cnt_q + 3'h1 == SAMPLE_EDGE_CNT)
                armed_q <= 1'b0;
        end
    end

    // latch on the fourth edge; synchroniser lag is accepted as strap setup
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            low_q      <= 1'b0;
            high_q     <= 1'b0;
            captured_q <= 1'b0;
        end
        else if (restart)
            captured_q <= 1'b0;
        else if (armed_q && edge_cnt_q + 3'h1 == SAMPLE_EDGE_CNT)
        begin
            low_q      <= sync2_q[0];
            high_q     <= sync2_q[1];
            captured_q <= 1'b1;
        end
    end

    assign straps.low_level  = low_q;
    assign straps.high_level = high_q;
    assign straps.captured   = captured_q;

endmodule
